// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        core_clk;
   logic        rst;
   logic        ce;
   logic [7:0]  bus_addr;
   logic [15:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [15:0] bus_rdata;
   logic        irq;
   logic [3:0]  dma_req;
   logic        upd_evt;
   logic        trg_evt;
   int          miscompares;
   int          n_tests;
   logic [15:0] rdat;
   logic [15:0] chb;
   logic [15:0] mode_ctrl [5] = '{16'h0000, 16'h0010, 16'h0030, 16'h0002, 16'h0004};
   logic [15:0] mode_cnt  [5] = '{16'h0000, 16'h0050, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] mode_flag [5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000};

   tev_timer dut (
      .CORE_CLK   (core_clk),
      .RST        (rst),
      .CE         (ce),
      .BUS_ADDR   (bus_addr),
      .BUS_WDATA  (bus_wdata),
      .BUS_WR     (bus_wr),
      .BUS_RD     (bus_rd),
      .BUS_RDATA  (bus_rdata),
      .IRQ        (irq),
      .DMA_REQ    (dma_req),
      .UPDATE_EVT (upd_evt),
      .TRIGGER_EVT(trg_evt)
   );

   always #5 core_clk = ~core_clk;

   // ==========================================================
   // Bus tasks
   // ==========================================================
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Returns just after the taking edge, so one-cycle pulses are visible
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rc(input string name, input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1;
      chk(name, exp, bus_rdata);
   endtask : rc

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   // Hang guard
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      core_clk    = 1'b0;
      rst         = 1'b1;
      ce          = 1'b1;
      bus_addr    = 8'h00;
      bus_wdata   = 16'h0000;
      bus_wr      = 1'b0;
      bus_rd      = 1'b0;
      miscompares = 0;
      n_tests     = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rc("event reset", tev_pkg::EVENT_OFS, 16'h0000);
      rc("reload reset", tev_pkg::RELOAD_OFS, 16'hffff);
      rc("unmapped", 8'h7c, 16'h0000);
      // Forced update in every count mode, counter stopped
      wr(tev_pkg::PRESC_OFS, 16'h0003);
      wr(tev_pkg::RELOAD_OFS, 16'h0050);
      wr(tev_pkg::COUNT_OFS, 16'h1234);
      wr(tev_pkg::EVENT_OFS, 16'h0000);
      chk("update on zero", 16'h0000, 16'(upd_evt));
      rc("count kept", tev_pkg::COUNT_OFS, 16'h1234);
      for (int i = 0; i < 5; i++) begin
         wr(tev_pkg::CTRL_OFS, mode_ctrl[i]);
         wr(tev_pkg::STATUS_OFS, 16'h0000);
         wr(tev_pkg::COUNT_OFS, 16'h1234);
         wr(tev_pkg::EVENT_OFS, 16'h0001);
         if (mode_flag[i] == 16'h0001) begin
            chk("update pulse", 16'h0001, 16'(upd_evt));
         end
         rc("count reinit", tev_pkg::COUNT_OFS, mode_cnt[i]);
         rc("update flag", tev_pkg::STATUS_OFS, mode_flag[i]);
      end
      rc("prescaler kept", tev_pkg::PRESC_OFS, 16'h0003);
      wr(tev_pkg::CTRL_OFS, 16'h0000);
      wr(tev_pkg::EVENT_OFS, 16'hffa0);
      chk("reserved update", 16'h0000, 16'(upd_evt));
      chk("reserved trigger", 16'h0000, 16'(trg_evt));
      rc("event readback", tev_pkg::EVENT_OFS, 16'h0000);
      // Each channel: output mode first, then input capture twice
      wr(tev_pkg::DMA_EN_OFS, 16'h0005);
      for (int k = 0; k < 4; k++) begin
         chb = 16'(1 << (k + 1));
         rc("pending drain", tev_pkg::IRQ_PEND_OFS, 16'(1 << k));
         rc("pending drain", tev_pkg::IRQ_PEND_OFS, 16'h0000);
         wr(tev_pkg::STATUS_OFS, 16'h0000);
         wr(tev_pkg::CH_MODE_OFS, 16'h0000);
         wr(tev_pkg::IRQ_EN_OFS, chb);
         chk("irq idle", 16'h0000, 16'(irq));
         wr(tev_pkg::EVENT_OFS, chb);
         @(posedge core_clk);
         #1;
         chk("dma", 16'((k % 2 == 0) ? (1 << k) : 0), 16'(dma_req));
         chk("irq", 16'h0001, 16'(irq));
         rc("out flag", tev_pkg::STATUS_OFS, chb);
         rc("pending", tev_pkg::IRQ_PEND_OFS, chb);
         chk("irq cleared", 16'h0000, 16'(irq));
         wr(tev_pkg::STATUS_OFS, 16'h0000);
         wr(tev_pkg::CH_MODE_OFS, 16'(1 << k));
         wr(tev_pkg::COUNT_OFS, 16'(16'h00a0 + k));
         wr(tev_pkg::EVENT_OFS, chb);
         rc("capture", 8'(tev_pkg::CH_VAL_OFS + 4 * k), 16'(16'h00a0 + k));
         rc("in flag", tev_pkg::STATUS_OFS, chb);
         wr(tev_pkg::EVENT_OFS, chb);
         rc("repeat flag", tev_pkg::STATUS_OFS, chb | 16'(1 << (9 + k)));
      end
      // Trigger request and its sticky flag
      rc("pending drain", tev_pkg::IRQ_PEND_OFS, 16'h0010);
      wr(tev_pkg::STATUS_OFS, 16'h0000);
      wr(tev_pkg::IRQ_EN_OFS, 16'h0040);
      wr(tev_pkg::EVENT_OFS, 16'h0040);
      chk("trigger pulse", 16'h0001, 16'(trg_evt));
      chk("trigger irq", 16'h0001, 16'(irq));
      @(posedge core_clk);
      #1;
      chk("trigger cleared", 16'h0000, 16'(trg_evt));
      rc("trigger flag", tev_pkg::STATUS_OFS, 16'h0040);
      wr(tev_pkg::STATUS_OFS, 16'hffff);
      rc("trigger kept", tev_pkg::STATUS_OFS, 16'h0040);
      wr(tev_pkg::STATUS_OFS, 16'h0000);
      rc("trigger clear", tev_pkg::STATUS_OFS, 16'h0000);
      // All requests in one write
      wr(tev_pkg::EVENT_OFS, 16'h005f);
      chk("all update", 16'h0001, 16'(upd_evt));
      chk("all trigger", 16'h0001, 16'(trg_evt));
      @(posedge core_clk);
      #1;
      chk("all dma", 16'h0005, 16'(dma_req));
      stop_test();
   end
endmodule : testbench
`default_nettype wire

// file: dv/tev_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Event generation checker
// ==========================================================
module tev_timer_chk #(
   parameter int unsigned NCH = tev_pkg::NCH
) (
   input wire logic                       CORE_CLK,
   input wire logic                       RST,
   input wire logic                       CE,
   input wire logic [tev_pkg::ADDR_W-1:0] BUS_ADDR,
   input wire logic [tev_pkg::DATA_W-1:0] BUS_WDATA,
   input wire logic                       BUS_WR,
   input wire logic                       BUS_RD,
   input wire logic [tev_pkg::DATA_W-1:0] BUS_RDATA,
   input wire logic                       IRQ,
   input wire logic [NCH-1:0]             DMA_REQ,
   input wire logic                       UPDATE_EVT,
   input wire logic                       TRIGGER_EVT
);
   logic ev_wr;
   logic trg_wr;
   logic ev_rd;

   assign ev_wr  = CE && BUS_WR && (BUS_ADDR == tev_pkg::EVENT_OFS);
   assign trg_wr = ev_wr && BUS_WDATA[tev_pkg::EV_TRIG_BIT];
   assign ev_rd  = CE && BUS_RD && (BUS_ADDR == tev_pkg::EVENT_OFS);

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   // ==========================================================
   // Properties
   // ==========================================================
   property p_upd_evt;
      ev_wr && BUS_WDATA[tev_pkg::EV_UPDATE_BIT] |=> UPDATE_EVT;
   endproperty
   a_upd_evt: assert property (p_upd_evt) else $error("no update pulse");

   property p_trg_evt;
      trg_wr |-> ##1 TRIGGER_EVT;
   endproperty
   a_trg_evt: assert property (p_trg_evt) else $error("no trigger pulse");

   property p_trg_cause;
      $rose(TRIGGER_EVT) |-> $past(trg_wr);
   endproperty
   a_trg_cause: assert property (p_trg_cause) else $error("trigger without request");

   // Self-clearing request: one write gives one pulse only
   property p_trg_clear;
      trg_wr ##1 !trg_wr |=> !TRIGGER_EVT;
   endproperty
   a_trg_clear: assert property (p_trg_clear) else $error("trigger request stuck");

   property p_rsvd;
      ev_wr && ((BUS_WDATA & 16'h005f) == 16'h0000) |=> !TRIGGER_EVT;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit acted");

   property p_ev_rd;
      ev_rd |=> BUS_RDATA == 16'h0000;
   endproperty
   a_ev_rd: assert property (p_ev_rd) else $error("event word read nonzero");

   property p_rd_idle;
      CE && !BUS_RD |=> BUS_RDATA == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

   property p_both;
      ev_wr && BUS_WDATA[0] && BUS_WDATA[6] |=> UPDATE_EVT && TRIGGER_EVT;
   endproperty
   a_both: assert property (p_both) else $error("combined request lost one");

   // ==========================================================
   // Coverage
   // ==========================================================
   c_upd: cover property (ev_wr && BUS_WDATA[0] ##1 UPDATE_EVT);
   c_trg: cover property (trg_wr ##1 TRIGGER_EVT);
   c_dma: cover property (DMA_REQ != '0);
endmodule : tev_timer_chk

bind tev_timer tev_timer_chk #(.NCH(NCH)) u_chk (
   .CORE_CLK   (CORE_CLK),
   .RST        (RST),
   .CE         (CE),
   .BUS_ADDR   (BUS_ADDR),
   .BUS_WDATA  (BUS_WDATA),
   .BUS_WR     (BUS_WR),
   .BUS_RD     (BUS_RD),
   .BUS_RDATA  (BUS_RDATA),
   .IRQ        (IRQ),
   .DMA_REQ    (DMA_REQ),
   .UPDATE_EVT (UPDATE_EVT),
   .TRIGGER_EVT(TRIGGER_EVT)
);
`default_nettype wire

// file: hw/tev_channel.sv
`timescale 1ns/10ps
`default_nettype none
module tev_channel (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire tev_pkg::tev_ch_in_t  ch_in,
   output tev_pkg::tev_ch_out_t      ch_out
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [15:0] value_reg;
      logic        flag_reg;
      logic        rep_reg;
      logic        event_reg;
   } tev_ch_state_t;

   tev_ch_state_t st_reg;
   tev_ch_state_t st_next;
   logic          hit;

   always_comb begin
      st_next   = st_reg;
      hit       = ch_in.force_ev | (ch_in.match_ev & ~ch_in.is_input);
      if (ch_in.wr_val && !ch_in.is_input) begin
         st_next.value_reg = ch_in.wdata;
      end
      // Clear first, so an event in the same cycle wins
      if (ch_in.clr_flag) begin
         st_next.flag_reg = 1'b0;
      end
      if (ch_in.clr_rep) begin
         st_next.rep_reg = 1'b0;
      end
      st_next.event_reg = hit;
      if (hit) begin
         st_next.flag_reg = 1'b1;
      end
      if (ch_in.force_ev && ch_in.is_input) begin
         st_next.value_reg = ch_in.count;
         if (st_reg.flag_reg && !ch_in.clr_flag) begin
            st_next.rep_reg = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign ch_out.value   = st_reg.value_reg;
   assign ch_out.flag    = st_reg.flag_reg;
   assign ch_out.rep     = st_reg.rep_reg;
   assign ch_out.event_p = st_reg.event_reg;
endmodule : tev_channel
`default_nettype wire

// file: hw/tev_pkg.sv
`default_nettype none
package tev_pkg;
   // ==========================================================
   // Widths
   // ==========================================================
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned NCH    = 4;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] DMA_EN_OFS   = 8'h08;
   localparam logic [7:0] IRQ_EN_OFS   = 8'h0c;
   localparam logic [7:0] STATUS_OFS   = 8'h10;
   localparam logic [7:0] EVENT_OFS    = 8'h14;
   localparam logic [7:0] CH_MODE_OFS  = 8'h18;
   localparam logic [7:0] IRQ_PEND_OFS = 8'h20;
   localparam logic [7:0] COUNT_OFS    = 8'h24;
   localparam logic [7:0] PRESC_OFS    = 8'h28;
   localparam logic [7:0] RELOAD_OFS   = 8'h2c;
   localparam logic [7:0] CH_VAL_OFS   = 8'h34;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned CTRL_EN_BIT     = 0;
   localparam int unsigned CTRL_UD_BIT     = 1;
   localparam int unsigned CTRL_USEL_BIT   = 2;
   localparam int unsigned CTRL_DOWN_BIT   = 4;
   localparam int unsigned CTRL_CENTER_BIT = 5;
   localparam int unsigned EV_UPDATE_BIT   = 0;
   localparam int unsigned EV_CH_LSB       = 1;
   localparam int unsigned EV_TRIG_BIT     = 6;
   localparam int unsigned ST_REP_LSB      = 9;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] RELOAD_RST = 16'hffff;
   localparam logic [15:0] ZERO_RST   = 16'h0000;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [0:0] {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } tev_dir_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tev_bus_req_t;

   typedef struct packed {
      logic        force_ev;
      logic        match_ev;
      logic        is_input;
      logic        clr_flag;
      logic        clr_rep;
      logic        wr_val;
      logic [15:0] wdata;
      logic [15:0] count;
   } tev_ch_in_t;

   typedef struct packed {
      logic [15:0] value;
      logic        flag;
      logic        rep;
      logic        event_p;
   } tev_ch_out_t;
endpackage : tev_pkg
`default_nettype wire

// file: hw/tev_timer.sv
// Operation
// - Writing one to update request reinitializes counter, raises update event, self-clears.
// - Update event zeroes prescaler count; programmed division factor stays.
// - Forced update loads reload value counting down, zero counting up or center.
// - Writing one to a channel request forces that channel's event, then self-clears.
// - Output-mode forced event sets channel flag; raises enabled interrupt and DMA.
// - Input-mode forced event captures counter, sets flag, raises enabled requests.
// - Forced capture while flag already set also sets repeat-capture flag.
// - Channels two to four have identical request bits at positions 2, 3, 4.
// - Writing one to trigger request produces a trigger event, then self-clears.
// - Forced update sets update flag when not disabled and source select zero.
// - Trigger event sets trigger flag until software clears it.
`timescale 1ns/10ps
`default_nettype none
module tev_timer #(
   parameter int unsigned NCH = tev_pkg::NCH
) (
   input  wire logic                       CORE_CLK,
   input  wire logic                       RST,
   input  wire logic                       CE,
   input  wire logic [tev_pkg::ADDR_W-1:0] BUS_ADDR,
   input  wire logic [tev_pkg::DATA_W-1:0] BUS_WDATA,
   input  wire logic                       BUS_WR,
   input  wire logic                       BUS_RD,
   output logic      [tev_pkg::DATA_W-1:0] BUS_RDATA,
   output logic                            IRQ,
   output logic      [NCH-1:0]             DMA_REQ,
   output logic                            UPDATE_EVT,
   output logic                            TRIGGER_EVT
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [15:0]      ctrl_reg;
      logic [NCH-1:0]   dma_en_reg;
      logic [15:0]      irq_en_reg;
      logic [15:0]      irq_pend_reg;
      logic             uflag_reg;
      logic             tflag_reg;
      logic [NCH-1:0]   ch_mode_reg;
      logic [15:0]      count_reg;
      logic [15:0]      presc_reg;
      logic [15:0]      presc_cnt_reg;
      logic [15:0]      reload_reg;
      tev_pkg::tev_dir_t dir_reg;
      logic [15:0]      rdata_reg;
      logic [NCH-1:0]   dma_reg;
      logic             upd_reg;
      logic             trig_reg;
   } tev_state_t;

   // ==============================
   // Signals
   // ==============================
   tev_state_t              st_reg;
   tev_state_t              st_next;
   tev_pkg::tev_bus_req_t   req;
   tev_pkg::tev_ch_in_t     ch_in  [NCH];
   tev_pkg::tev_ch_out_t    ch_out [NCH];
   logic                    ev_wr;
   logic                    st_wr;
   logic                    force_upd;
   logic                    force_trig;
   logic [NCH-1:0]          force_ch;
   logic [NCH-1:0]          ch_ev;
   logic                    tick;
   logic                    wrap_upd;
   logic                    count_down;
   logic                    center;
   logic [15:0]             status_word;
   logic [15:0]             ev_set;
   logic [15:0]             rd_word;

   // ==============================
   // Bus port
   // ==============================
   assign req.wr    = BUS_WR;
   assign req.rd    = BUS_RD;
   assign req.addr  = BUS_ADDR;
   assign req.wdata = BUS_WDATA;

   // ==========================================================
   // Request decode
   // ==========================================================
   // Requests act on the write edge itself; nothing is stored,
   // so the word can never be read back as one.
   assign ev_wr      = req.wr && (req.addr == tev_pkg::EVENT_OFS);
   assign st_wr      = req.wr && (req.addr == tev_pkg::STATUS_OFS);
   assign force_upd  = ev_wr & req.wdata[tev_pkg::EV_UPDATE_BIT];
   assign force_trig = ev_wr & req.wdata[tev_pkg::EV_TRIG_BIT];
   assign force_ch   = {NCH{ev_wr}} & req.wdata[tev_pkg::EV_CH_LSB +: NCH];

   // ==============================
   // Counter controls
   // ==============================
   // Center mode wins over the direction bit
   assign count_down = st_reg.ctrl_reg[tev_pkg::CTRL_DOWN_BIT];
   assign center     = st_reg.ctrl_reg[tev_pkg::CTRL_CENTER_BIT];
   assign tick       = st_reg.ctrl_reg[tev_pkg::CTRL_EN_BIT] &&
                       (st_reg.presc_cnt_reg == st_reg.presc_reg);

   // ==========================================================
   // Channels
   // ==========================================================
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      always_comb begin
         ch_in[i].force_ev = force_ch[i];
         ch_in[i].match_ev = tick && (st_reg.count_reg == ch_out[i].value);
         ch_in[i].is_input = st_reg.ch_mode_reg[i];
         ch_in[i].clr_flag = st_wr & ~req.wdata[tev_pkg::EV_CH_LSB + i];
         ch_in[i].clr_rep  = st_wr & ~req.wdata[tev_pkg::ST_REP_LSB + i];
         ch_in[i].wr_val   = req.wr &&
                             (req.addr == 8'(tev_pkg::CH_VAL_OFS + 8'(4 * i)));
         ch_in[i].wdata    = req.wdata;
         ch_in[i].count    = st_reg.count_reg;
      end

      tev_channel u_ch (
         .clk    (CORE_CLK),
         .rst    (RST),
         .ce     (CE),
         .ch_in  (ch_in[i]),
         .ch_out (ch_out[i])
      );

      assign ch_ev[i] = ch_out[i].event_p;
   end

   // ==========================================================
   // Status word
   // ==========================================================
   always_comb begin
      status_word = '0;
      status_word[tev_pkg::EV_UPDATE_BIT] = st_reg.uflag_reg;
      status_word[tev_pkg::EV_TRIG_BIT]   = st_reg.tflag_reg;
      for (int k = 0; k < NCH; k++) begin
         status_word[tev_pkg::EV_CH_LSB + k]  = ch_out[k].flag;
         status_word[tev_pkg::ST_REP_LSB + k] = ch_out[k].rep;
      end
   end

   // ==========================================================
   // Read mux
   // ==========================================================
   always_comb begin
      rd_word = '0;
      case (req.addr)
         tev_pkg::CTRL_OFS:     rd_word = st_reg.ctrl_reg;
         tev_pkg::DMA_EN_OFS:   rd_word = 16'(st_reg.dma_en_reg);
         tev_pkg::IRQ_EN_OFS:   rd_word = st_reg.irq_en_reg;
         tev_pkg::STATUS_OFS:   rd_word = status_word;
         tev_pkg::EVENT_OFS:    rd_word = 16'h0000;
         tev_pkg::CH_MODE_OFS:  rd_word = 16'(st_reg.ch_mode_reg);
         tev_pkg::IRQ_PEND_OFS: rd_word = st_reg.irq_pend_reg;
         tev_pkg::COUNT_OFS:    rd_word = st_reg.count_reg;
         tev_pkg::PRESC_OFS:    rd_word = st_reg.presc_reg;
         tev_pkg::RELOAD_OFS:   rd_word = st_reg.reload_reg;
         default: begin
            rd_word = '0;
            for (int k = 0; k < NCH; k++) begin
               if (req.addr == 8'(tev_pkg::CH_VAL_OFS + 8'(4 * k))) begin
                  rd_word = ch_out[k].value;
               end
            end
         end
      endcase
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_next          = st_reg;
      wrap_upd         = 1'b0;
      ev_set           = '0;
      st_next.upd_reg  = 1'b0;
      st_next.trig_reg = 1'b0;
      st_next.rdata_reg = 16'h0000;

      // ==============================
      // Register writes
      // ==============================
      if (req.wr) begin
         case (req.addr)
            tev_pkg::CTRL_OFS:    st_next.ctrl_reg    = req.wdata;
            tev_pkg::DMA_EN_OFS:  st_next.dma_en_reg  = req.wdata[NCH-1:0];
            tev_pkg::IRQ_EN_OFS:  st_next.irq_en_reg  = req.wdata;
            tev_pkg::CH_MODE_OFS: st_next.ch_mode_reg = req.wdata[NCH-1:0];
            tev_pkg::COUNT_OFS:   st_next.count_reg   = req.wdata;
            tev_pkg::PRESC_OFS:   st_next.presc_reg   = req.wdata;
            tev_pkg::RELOAD_OFS:  st_next.reload_reg  = req.wdata;
            default: begin
            end
         endcase
      end

      // ==============================
      // Status clears
      // ==============================
      if (st_wr) begin
         // Write zero clears, write one leaves the flag alone
         if (!req.wdata[tev_pkg::EV_UPDATE_BIT]) begin
            st_next.uflag_reg = 1'b0;
         end
         if (!req.wdata[tev_pkg::EV_TRIG_BIT]) begin
            st_next.tflag_reg = 1'b0;
         end
      end

      // ==============================
      // Prescaler and counter
      // ==============================
      // Divides by value plus one
      if (tick) begin
         st_next.presc_cnt_reg = 16'h0000;
         if (center) begin
            case (st_reg.dir_reg)
               tev_pkg::DIR_UP: begin
                  if (st_reg.count_reg >= st_reg.reload_reg) begin
                     st_next.count_reg = st_reg.count_reg - 16'h0001;
                     st_next.dir_reg   = tev_pkg::DIR_DOWN;
                     wrap_upd          = 1'b1;
                  end else begin
                     st_next.count_reg = st_reg.count_reg + 16'h0001;
                  end
               end
               tev_pkg::DIR_DOWN: begin
                  if (st_reg.count_reg == 16'h0000) begin
                     st_next.count_reg = 16'h0001;
                     st_next.dir_reg   = tev_pkg::DIR_UP;
                     wrap_upd          = 1'b1;
                  end else begin
                     st_next.count_reg = st_reg.count_reg - 16'h0001;
                  end
               end
               default: begin
                  st_next.dir_reg = tev_pkg::DIR_UP;
               end
            endcase
         end else if (count_down) begin
            if (st_reg.count_reg == 16'h0000) begin
               st_next.count_reg = st_reg.reload_reg;
               wrap_upd          = 1'b1;
            end else begin
               st_next.count_reg = st_reg.count_reg - 16'h0001;
            end
         end else begin
            if (st_reg.count_reg >= st_reg.reload_reg) begin
               st_next.count_reg = 16'h0000;
               wrap_upd          = 1'b1;
            end else begin
               st_next.count_reg = st_reg.count_reg + 16'h0001;
            end
         end
      end else if (st_reg.ctrl_reg[tev_pkg::CTRL_EN_BIT]) begin
         st_next.presc_cnt_reg = st_reg.presc_cnt_reg + 16'h0001;
      end

      // ==============================
      // Natural wrap only flags when updates are enabled
      // ==============================
      if (wrap_upd && !st_reg.ctrl_reg[tev_pkg::CTRL_UD_BIT]) begin
         st_next.uflag_reg = 1'b1;
         st_next.upd_reg   = 1'b1;
         ev_set[tev_pkg::EV_UPDATE_BIT] = 1'b1;
      end

      // ==============================
      // Forced update overrides counting in the same cycle
      // ==============================
      // Reload and update pulse happen even with updates disabled; only the flag and its pending bit are gated
      if (force_upd) begin
         st_next.presc_cnt_reg = 16'h0000;
         st_next.upd_reg       = 1'b1;
         if (count_down && !center) begin
            st_next.count_reg = st_reg.reload_reg;
         end else begin
            st_next.count_reg = 16'h0000;
            st_next.dir_reg   = tev_pkg::DIR_UP;
         end
         if (!st_reg.ctrl_reg[tev_pkg::CTRL_UD_BIT] &&
             !st_reg.ctrl_reg[tev_pkg::CTRL_USEL_BIT]) begin
            st_next.uflag_reg = 1'b1;
            ev_set[tev_pkg::EV_UPDATE_BIT] = 1'b1;
         end
      end

      // ==============================
      // Trigger request
      // ==============================
      if (force_trig) begin
         st_next.tflag_reg = 1'b1;
         st_next.trig_reg  = 1'b1;
         ev_set[tev_pkg::EV_TRIG_BIT] = 1'b1;
      end

      // ==============================
      // Channel events reach interrupt and DMA one cycle after the flag
      // ==============================
      // DMA strobe is one cycle; a held level would repeat transfers
      ev_set[tev_pkg::EV_CH_LSB +: NCH] = ch_ev;
      st_next.dma_reg = ch_ev & st_reg.dma_en_reg;

      // ==============================
      // Read data, and read-to-clear of the pending word
      // ==============================
      // Only the pending word has a read side effect
      if (req.rd) begin
         st_next.rdata_reg = rd_word;
         if (req.addr == tev_pkg::IRQ_PEND_OFS) begin
            st_next.irq_pend_reg = 16'h0000;
         end
      end
      // Set after clear: an event never falls into a clearing read
      st_next.irq_pend_reg = st_next.irq_pend_reg | ev_set;
   end

   // ==============================
   // Registers
   // ==============================
   // CE low holds every field; strobes seen then are lost
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_reg            <= '0;
         st_reg.ctrl_reg   <= tev_pkg::CTRL_RST;
         st_reg.reload_reg <= tev_pkg::RELOAD_RST;
         st_reg.dir_reg    <= tev_pkg::DIR_UP;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign BUS_RDATA   = st_reg.rdata_reg;
   assign IRQ         = |(st_reg.irq_pend_reg & st_reg.irq_en_reg);
   assign DMA_REQ     = st_reg.dma_reg;
   assign UPDATE_EVT  = st_reg.upd_reg;
   assign TRIGGER_EVT = st_reg.trig_reg;
endmodule : tev_timer
`default_nettype wire
